// ### hdl/lmc_mode_ctrl.sv
// load modulation mode control: ownership of the modulation switches and helpers
// What this block does
// - config pin below 250mV selects bypass
// - grounded config gives the switches to the host input, never the integrated modulator, for as long as the strap holds
// - resistor config starts standalone after reset
// - standalone supply target is resistor over 5000
// - standalone modulator regulates supply autonomously
// - eight pulses under 25ms apart enter bypass
// - under eight pulses per 250ms returns standalone
// - bypass: host input high closes switches
// - both switches grounded together, momentarily
// - dummy 10mA load while buck is off
// - buck on above 4V, hysteresis, off without AC
// - open-drain output at AC frequency over 8
// - alert pulled low only on transmitter command
// - logic held in reset until supply passes POR
`timescale 1ns/10ps

// operating notes for whoever picks this block up next
//
// ownership of the two load switches
//   the mode register says who drives the switches. in standalone the
//   integrated modulator bit (modulator_drive_i) is copied to both switches
//   one cycle late. in bypass and grounded the synchronised host input is
//   copied instead, three cycles after the pin, through the same flops that
//   feed the pulse counter, so the switches and the counter agree on what
//   the host did.
//
// strap handling
//   the grounded strap is a level that is looked at on every clock, not
//   only once after reset. a strap that drops away mid-run returns the
//   block to standalone, which is the safe owner when nobody else is known
//   to be alive. while the strap holds, neither the handover counter nor
//   the fallback window can move the mode away from grounded.
//
// handover counting
//   one pulse is one rising edge of the synchronised host input. the gap
//   timer saturates at the spacing limit, so a long silence is never
//   mistaken for a short one after a wrap. a pulse that comes after too
//   long a gap starts a new run counted from one, not from zero, because
//   that pulse itself belongs to the new run.
//
// fallback window
//   in bypass a free-running window counts pulses. the count taken at the
//   window's last cycle includes a pulse that lands in that same cycle;
//   only after the decision is the count cleared for the next window.
//   the window is restarted from zero on every entry to bypass, so a host
//   that hands over late in a window is not judged on a short window.
//
// limitations
//   the host input and the ac clock are sampled by this clock, so both
//   must stay well below half of it; pulses narrower than a clock period
//   can be lost. the supply target is a plain integer quotient and drops
//   any fraction of the divisor.
//
// register bus
//   every request is answered one cycle after it is taken, with no other
//   wait states. a write lands at the edge that takes the request; read
//   data is captured at that same edge and stands together with ack.
//   only the low byte lane carries writable bits, so sel[0] gates writes.
//
// interrupts
//   three sticky status bits: entry to bypass, return to standalone and
//   a new alert command. writing a one clears a bit, but an event in the
//   same cycle wins over the clear so that no event is ever lost. the
//   irq output is registered from the next status and mask, so it changes in the same cycle as they do.
//
// open-drain outputs
//   both open-drain pins drive a constant low and are switched by their
//   output enables; an enable that is high pulls the pin down. reset
//   leaves the alert pin released, as the host may be starting then.
//
// reset
//   the block is held in reset while the supply is below the power-on
//   level, in addition to the ordinary reset input. all state returns to
//   standalone with the gap timer parked at its limit and the window timer at zero.
//
module lmc_mode_ctrl
  import lmc_pkg::*;
#(
  parameter int unsigned SPACING_CYCLES = SPACING_CYC,
  parameter int unsigned WINDOW_CYCLES = WINDOW_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // analogue monitors and pins
  input wire lmc_ana_t ana_i,
  input wire logic [31:0] config_resistor_i,
  input wire logic host_modulation_input_i,
  input wire logic ac_clk_i,
  input wire logic modulator_drive_i,
  input wire logic alert_cmd_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // switches and outputs
  output logic load_switch_one_o,
  output logic load_switch_two_o,
  output logic ac_div_out_a_o,
  output logic ac_div_out_a_oe_o,
  output logic host_alert_n_o,
  output logic host_alert_n_oe_o,
  output logic buck_enable_o,
  output logic dummy_load_en_o,
  output logic [TGT_W-1:0] supply_target_o,
  output logic standalone_o,
  output logic irq_o
);

  lmc_state_t st_reg, st_next;
  logic [TGT_W-1:0] target_reg;
  logic rst_all;
  logic host_rise;
  logic ac_rise;
  logic req;
  logic [IRQ_W-1:0] evt;
  logic [31:0] rdat;

  // internal logic stays in reset until the supply clears the POR level
  assign rst_all = sys_rst_i | ~ana_i.supply_por_ok;

  // read multiplexer as a function of address
  function automatic logic [31:0] rd_mux(input lmc_state_t s, input logic [7:0] a,
                                         input logic [TGT_W-1:0] t);
    logic [31:0] r;
    r = UNMAPPED_DATA;
    if (a == ADDR_CTRL) begin
      r[0] = s.force_sa;
    end else if (a == ADDR_STAT) begin
      r[1:0] = s.mode;
      r[2] = s.buck_on;
      r[3] = s.dummy_load;
      r[7:4] = s.pulse_cnt;
      r[11:8] = s.win_pulses;
    end else if (a == ADDR_IRQ) begin
      r[IRQ_W-1:0] = s.irq_stat;
    end else if (a == ADDR_MASK) begin
      r[IRQ_W-1:0] = s.irq_mask;
    end else if (a == ADDR_TGT) begin
      r[TGT_W-1:0] = t;
    end
    return r;
  endfunction

  // next state
  always_comb begin
    st_next = st_reg;
    evt = '0;
    req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    // three flops; the first is only read by the second
    st_next.mod_s1 = host_modulation_input_i;
    st_next.mod_s2 = st_reg.mod_s1;
    st_next.mod_s3 = st_reg.mod_s2;
    host_rise = st_reg.mod_s2 & ~st_reg.mod_s3;
    st_next.ac_s1 = ac_clk_i;
    st_next.ac_s2 = st_reg.ac_s1;
    st_next.ac_s3 = st_reg.ac_s2;
    ac_rise = st_reg.ac_s2 & ~st_reg.ac_s3;
    rdat = rd_mux(st_reg, wb_adr_i, target_reg);

    // the gap timer saturates rather than wraps, so a long silence stays long
    if (st_reg.gap_cnt != CNT_W'(SPACING_CYCLES)) begin
      st_next.gap_cnt = st_reg.gap_cnt + 1'b1;
    end
    case (st_reg.mode)
      LMC_ST_STANDALONE: begin
        if (host_rise) begin
          st_next.gap_cnt = '0;
          // gap too long restarts the run with this pulse as the first
          if (st_reg.gap_cnt >= CNT_W'(SPACING_CYCLES) && st_reg.pulse_cnt != '0) begin
            st_next.pulse_cnt = PCNT_W'(1);
          end else begin
            st_next.pulse_cnt = st_reg.pulse_cnt + 1'b1;
          end
          if (st_next.pulse_cnt >= PCNT_W'(PULSE_MIN) && !st_reg.force_sa) begin
            st_next.mode = LMC_ST_BYPASS;
            st_next.pulse_cnt = '0;
            st_next.win_cnt = '0;
            st_next.win_pulses = '0;
            evt[IRQ_TO_BYP] = 1'b1;
          end
        end
      end
      LMC_ST_BYPASS: begin
        st_next.win_cnt = st_reg.win_cnt + 1'b1;
        if (host_rise && st_reg.win_pulses != PCNT_W'(PULSE_MIN)) begin
          st_next.win_pulses = st_reg.win_pulses + 1'b1;
        end
        if (st_reg.win_cnt == CNT_W'(WINDOW_CYCLES - 1)) begin
          // judge the window, counting a pulse of this very cycle, then clear it
          if (st_next.win_pulses < PCNT_W'(PULSE_MIN) || st_reg.force_sa) begin
            st_next.mode = LMC_ST_STANDALONE;
            st_next.gap_cnt = CNT_W'(SPACING_CYCLES);
            st_next.pulse_cnt = '0;
            evt[IRQ_TO_SA] = 1'b1;
          end
          st_next.win_cnt = '0;
          st_next.win_pulses = '0;
        end
      end
      default: begin
        st_next.mode = LMC_ST_GROUNDED;
      end
    endcase

    // strap is a level, watched every cycle; it overrides any handover
    if (ana_i.cfg_grounded) begin
      st_next.mode = LMC_ST_GROUNDED;
    end else if (st_reg.mode == LMC_ST_GROUNDED) begin
      st_next.mode = LMC_ST_STANDALONE;
    end

    // switch drive: both together, only while a modulation bit is active
    if (st_reg.mode == LMC_ST_STANDALONE) begin
      st_next.sw_on = modulator_drive_i;
    end else begin
      st_next.sw_on = st_reg.mod_s2;
    end

    // buck enable with hysteresis; AC loss forces off
    if (!ana_i.ac_present) begin
      st_next.buck_on = 1'b0;
    end else if (ana_i.supply_above_on) begin
      st_next.buck_on = 1'b1;
    end else if (!ana_i.supply_above_off) begin
      st_next.buck_on = 1'b0;
    end
    st_next.dummy_load = ~st_next.buck_on;

    // divide by 8: toggle every 4 AC rising edges
    if (ac_rise) begin
      st_next.ac_div = st_reg.ac_div + 1'b1;
      if (st_reg.ac_div == 2'(AC_DIV / 2 - 1)) begin
        st_next.ac_div_out_a_lvl = ~st_reg.ac_div_out_a_lvl;
      end
    end

    st_next.alert_lvl = alert_cmd_i;
    evt[IRQ_ALERT] = alert_cmd_i & ~st_reg.alert_lvl;

    // wishbone: one wait state, ack one cycle
    st_next.ack = req;
    if (req) begin
      st_next.dat = rdat;
    end
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ADDR_CTRL) begin
        st_next.force_sa = wb_dat_i[0];
      end else if (wb_adr_i == ADDR_IRQ) begin
        st_next.irq_stat = st_reg.irq_stat & ~wb_dat_i[IRQ_W-1:0];
      end else if (wb_adr_i == ADDR_MASK) begin
        st_next.irq_mask = wb_dat_i[IRQ_W-1:0];
      end
    end
    // set wins over a clear in the same cycle
    st_next.irq_stat = st_next.irq_stat | evt;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
  end

  // state register; strap followed on every clock from the first clock after reset release
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      st_reg <= '0;
      st_reg.gap_cnt <= CNT_W'(SPACING_CYCLES);
      target_reg <= '0;
    end else begin
      st_reg <= st_next;
      target_reg <= TGT_W'(config_resistor_i / TARGET_DIV);
    end
  end

  // outputs straight from flops
  assign load_switch_one_o = st_reg.sw_on;
  assign load_switch_two_o = st_reg.sw_on;
  assign ac_div_out_a_o = 1'b0;
  assign ac_div_out_a_oe_o = ~st_reg.ac_div_out_a_lvl;
  assign host_alert_n_o = 1'b0;
  assign host_alert_n_oe_o = st_reg.alert_lvl;
  assign buck_enable_o = st_reg.buck_on;
  assign dummy_load_en_o = st_reg.dummy_load;
  assign supply_target_o = target_reg;
  assign standalone_o = (st_reg.mode == LMC_ST_STANDALONE);
  assign irq_o = st_reg.irq;
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;

endmodule

// ### hdl/lmc_pkg.sv
// package: constants and carrier types for the load modulation mode control block
package lmc_pkg;
  // timing in milliseconds and the system clock rate
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned SPACING_MS = 25;
  localparam int unsigned WINDOW_MS = 250;
  localparam int unsigned SPACING_CYC = (CLK_HZ / 1000) * SPACING_MS;
  localparam int unsigned WINDOW_CYC = (CLK_HZ / 1000) * WINDOW_MS;
  localparam int unsigned PULSE_MIN = 8;
  localparam int unsigned AC_DIV = 8;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned PCNT_W = 4;
  localparam int unsigned TGT_W = 16;
  // rectified supply target: resistor value divided by this
  localparam int unsigned TARGET_DIV = 5000;
  // register map (word offsets are byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_TGT = 8'h10;
  // interrupt bit positions
  localparam int unsigned IRQ_TO_BYP = 0;
  localparam int unsigned IRQ_TO_SA = 1;
  localparam int unsigned IRQ_ALERT = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // modulator ownership, gray along standalone -> bypass -> grounded
  typedef enum logic [1:0] {
    LMC_ST_STANDALONE = 2'b00,
    LMC_ST_BYPASS = 2'b01,
    LMC_ST_GROUNDED = 2'b11
  } lmc_mode_t;

  // analogue status taken in from the supply monitors
  typedef struct packed {
    logic cfg_grounded;
    logic supply_por_ok;
    logic supply_above_on;
    logic supply_above_off;
    logic ac_present;
  } lmc_ana_t;

  // whole state of the control block except the supply target, which is held in its own register
  typedef struct packed {
    lmc_mode_t mode;
    logic mod_s1;
    logic mod_s2;
    logic mod_s3;
    logic [CNT_W-1:0] gap_cnt;
    logic [CNT_W-1:0] win_cnt;
    logic [PCNT_W-1:0] pulse_cnt;
    logic [PCNT_W-1:0] win_pulses;
    logic ac_s1;
    logic ac_s2;
    logic ac_s3;
    logic [1:0] ac_div;
    logic ac_div_out_a_lvl;
    logic buck_on;
    logic dummy_load;
    logic sw_on;
    logic alert_lvl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic force_sa;
    logic ack;
    logic [31:0] dat;
  } lmc_state_t;
endpackage

// ### verif/lmc_host_model.sv
// host controller model: bursts of modulation pulses at a set spacing
`timescale 1ns/10ps
module lmc_host_model (
  // clock and burst request
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic [4:0] count_i,
  input wire logic [7:0] gap_i,
  // pin drive
  output logic host_mod_o,
  output logic busy_o
);
  // idle low, like the pin's pull-down
  initial begin
    host_mod_o = 1'b0;
    busy_o = 1'b0;
  end
  // a burst stands for a control packet; gap is rise to rise, pulses two cycles wide
  always @(posedge sys_clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      for (int k = 0; k < int'(count_i); k++) begin
        host_mod_o <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        host_mod_o <= 1'b0;
        repeat (gap_i - 8'h02) @(posedge sys_clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule

// ### verif/lmc_mode_ctrl_properties.sv
// checker: port timing relations of the mode control block
`timescale 1ns/10ps
module lmc_chk
  import lmc_pkg::*;
#(
  parameter int unsigned SPACING_CYCLES = SPACING_CYC,
  parameter int unsigned WINDOW_CYCLES = WINDOW_CYC
) (
  // clock, reset and inputs
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire lmc_ana_t ana_i,
  input wire logic [31:0] config_resistor_i,
  input wire logic host_modulation_input_i,
  input wire logic modulator_drive_i,
  input wire logic alert_cmd_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  // outputs watched
  input wire logic wb_ack_o,
  input wire logic load_switch_one_o,
  input wire logic load_switch_two_o,
  input wire logic host_alert_n_oe_o,
  input wire logic buck_enable_o,
  input wire logic dummy_load_en_o,
  input wire logic [TGT_W-1:0] supply_target_o,
  input wire logic standalone_o
);
  logic live;
  // skip the first edge after reset so $past never sees reset values
  always_ff @(posedge sys_clk_i) begin
    live <= !sys_rst_i && ana_i.supply_por_ok;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i || !ana_i.supply_por_ok || !live);
  // bus cycle steps
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_wb_ack_once: assert property (wb_req |=> ack_once)
    else $error("bus ack not a single cycle after request");
  chk_sw_pair: assert property (load_switch_one_o == load_switch_two_o)
    else $error("load switches differ");
  chk_grounded_bypass: assert property (ana_i.cfg_grounded [*2] |-> !standalone_o)
    else $error("standalone while strap grounded");
  chk_sa_drive: assert property ($past(standalone_o) && standalone_o
    |-> load_switch_one_o == $past(modulator_drive_i)) else $error("standalone drive wrong");
  chk_byp_follow: assert property (!standalone_o [*4]
    |-> load_switch_one_o == $past(host_modulation_input_i, 3)) else $error("bypass drive wrong");
  chk_target_div: assert property ($stable(config_resistor_i)
    |-> supply_target_o == TGT_W'(config_resistor_i / TARGET_DIV)) else $error("target wrong");
  chk_dummy_load: assert property (buck_enable_o != dummy_load_en_o)
    else $error("dummy load not opposite buck");
  chk_buck_noac: assert property (!ana_i.ac_present |=> !buck_enable_o)
    else $error("buck on without ac");
  chk_buck_low: assert property (!ana_i.supply_above_off |=> !buck_enable_o)
    else $error("buck on below falling threshold");
  chk_alert_follow: assert property (host_alert_n_oe_o == $past(alert_cmd_i))
    else $error("alert pull not following command");
endmodule
bind lmc_mode_ctrl lmc_chk #(
  .SPACING_CYCLES(SPACING_CYCLES),
  .WINDOW_CYCLES(WINDOW_CYCLES)
) i_chk (.*);

// ### verif/tb.sv
// testbench: handover, fallback, strap, buck, alert, divider and registers
`timescale 1ns/10ps
module tb;
  import lmc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, acc = 1'b0, mdrv = 1'b0, alrt = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hmi, busy, ack, fq, fqoe, al, aloe, bk, dl, sa, irq;
  logic s1, s2;
  logic [4:0] np = 5'h00;
  logic [7:0] adr = 8'h00, gap = 8'h0A;
  logic [31:0] dw = 32'h0, res = 32'h0, dr, q;
  logic [TGT_W-1:0] tgt;
  lmc_ana_t ana = 5'h0F;
  int err_total = 0, n_tests = 0;
  // clock and free running stimulus; ac toggles every five cycles
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) mdrv <= ~mdrv;
  always begin
    repeat (5) @(posedge clk);
    acc <= ~acc;
  end
  lmc_mode_ctrl #(.SPACING_CYCLES(20), .WINDOW_CYCLES(400)) i_dut (.sys_clk_i(clk),
    .sys_rst_i(rst), .ana_i(ana), .config_resistor_i(res), .host_modulation_input_i(hmi),
    .ac_clk_i(acc), .modulator_drive_i(mdrv), .alert_cmd_i(alrt), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .load_switch_one_o(s1), .load_switch_two_o(s2),
    .ac_div_out_a_o(fq), .ac_div_out_a_oe_o(fqoe), .host_alert_n_o(al),
    .host_alert_n_oe_o(aloe), .buck_enable_o(bk), .dummy_load_en_o(dl),
    .supply_target_o(tgt), .standalone_o(sa), .irq_o(irq));
  lmc_host_model i_host (.sys_clk_i(clk), .go_i(go), .count_i(np), .gap_i(gap),
    .host_mod_o(hmi), .busy_o(busy));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; data is taken at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    for (int i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    chk("bus ack", 1'b1, ack);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) wrap_up();
    @(posedge clk);
  endtask
  task automatic wait_sa(input logic v);
    for (int i = 0; i < 1500 && sa !== v; i++) @(posedge clk);
    chk("standalone", v, sa);
    if (sa !== v) wrap_up();
  endtask
  task automatic pulse(input logic [4:0] n, input logic [7:0] g);
    np <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 3000 && busy; i++) @(posedge clk);
    repeat (30) @(posedge clk);
  endtask
  task automatic t_target;
    res <= 32'd60000;
    repeat (4) @(posedge clk);
    chk("target", 32'd12, tgt);
    wb(1'b0, ADDR_TGT, 32'h0);
    chk("target reg", 32'd12, q);
    wb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", UNMAPPED_DATA, q);
  endtask
  // seven pulses or wide spacing keep standalone; eight close ones hand over
  task automatic t_mode;
    wait_sa(1'b1);
    pulse(5'd7, 8'd10);
    chk("seven pulses", 1'b1, sa);
    pulse(5'd10, 8'd30);
    chk("wide spacing", 1'b1, sa);
    pulse(5'd8, 8'd10);
    wait_sa(1'b0);
    wb(1'b0, ADDR_STAT, 32'h0);
    chk("mode bypass", 32'h1, q & 32'h3);
    pulse(5'd31, 8'd10);
    chk("busy host stays", 1'b0, sa);
    wait_sa(1'b1);
    wb(1'b0, ADDR_IRQ, 32'h0);
    chk("irq status", 32'h3, q & 32'h7);
    chk("irq masked", 1'b0, irq);
    wb(1'b1, ADDR_MASK, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq out", 1'b1, irq);
    wb(1'b1, ADDR_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked again", 1'b0, irq);
    wb(1'b1, ADDR_IRQ, 32'h3);
    wb(1'b0, ADDR_IRQ, 32'h0);
    chk("irq cleared", 32'h0, q & 32'h7);
    wb(1'b1, ADDR_MASK, 32'h0);
  endtask
  task automatic t_buck;
    ana.supply_above_on <= 1'b0;
    ana.supply_above_off <= 1'b0;
    repeat (4) @(posedge clk);
    chk("buck low", 1'b0, bk);
    chk("dummy on", 1'b1, dl);
    ana.supply_above_on <= 1'b1;
    ana.supply_above_off <= 1'b1;
    repeat (4) @(posedge clk);
    chk("buck on", 1'b1, bk);
    ana.supply_above_on <= 1'b0;
    repeat (4) @(posedge clk);
    chk("buck hysteresis", 1'b1, bk);
    chk("dummy off", 1'b0, dl);
    ana.supply_above_on <= 1'b1;
    ana.ac_present <= 1'b0;
    repeat (4) @(posedge clk);
    chk("buck no ac", 1'b0, bk);
    ana.ac_present <= 1'b1;
  endtask
  task automatic t_alert;
    chk("alert idle", 1'b0, aloe);
    alrt <= 1'b1;
    repeat (3) @(posedge clk);
    chk("alert pull", 1'b1, aloe);
    alrt <= 1'b0;
    wb(1'b0, ADDR_IRQ, 32'h0);
    chk("alert irq", 32'h4, q & 32'h7);
    wb(1'b1, ADDR_IRQ, 32'h4);
  endtask
  // ac period ten cycles, so the divided output rises once per eighty
  task automatic t_ac_div_out_a;
    int n;
    logic p;
    n = 0;
    p = fqoe;
    repeat (800) begin
      @(posedge clk);
      if (fqoe && !p) n++;
      p = fqoe;
    end
    chk("ac_div_out_a rises", 32'd10, n);
    chk("ac_div_out_a pin low", 1'b0, fq);
  endtask
  task automatic t_ground;
    ana.cfg_grounded <= 1'b1;
    pulse(5'd2, 8'd10);
    repeat (500) @(posedge clk);
    chk("grounded", 1'b0, sa);
    wb(1'b0, ADDR_STAT, 32'h0);
    chk("mode grounded", 32'h3, q & 32'h3);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_target;
    t_mode;
    t_buck;
    t_alert;
    t_ac_div_out_a;
    t_ground;
    wrap_up;
  end
endmodule
